// file: rtl/wmc_pkg.sv
/*
 * Package for the wake-up misc control register: offsets, bit positions,
 * reset values and LED option encodings.
 * Assumes the includer addresses registers relative to the unit base.
 */
package wmc_pkg;
    // ****************************************
    // Register window
    // ****************************************
    localparam int         ADDR_W             = 4;
    localparam logic [3:0] OFF_STD_LED        = 4'h0;
    localparam logic [3:0] OFF_MISC_CTL       = 4'h1;
    localparam logic [3:0] OFF_ADV_SPC_LED    = 4'h2;
    localparam logic [3:0] OFF_BLINK_LED      = 4'h3;
    localparam logic [3:0] OFF_KBD_WAKE       = 4'h4;
    localparam logic [3:0] OFF_PS2_CTL        = 4'h5;
    localparam logic [3:0] OFF_KEY_FIRST      = 4'h8;
    localparam logic [3:0] OFF_KEY_LAST       = 4'hF;
    localparam int         BASE_CFG_IDX_LO    = 'h60;
    localparam int         BASE_CFG_IDX_HI    = 'h61;

    // ****************************************
    // Field layout
    // ****************************************
    localparam int BIT_LOCK     = 7;
    localparam int BIT_BAT_GOOD = 5;
    localparam int BIT_LAST_PWR = 2;
    localparam int BIT_LED_HI   = 1;
    localparam int BIT_LED_LO   = 0;
    localparam int BIT_STD_BLK  = 1;
    localparam int BIT_STD_COL  = 0;

    typedef enum logic [1:0] {
        WMC_LED_ADV = 2'h0,
        WMC_LED_STD = 2'h1,
        WMC_LED_SPC = 2'h2,
        WMC_LED_RSV = 2'h3
    } wmc_led_option_select_t;

    localparam logic        LOCK_RST     = 1'h0;
    localparam logic        BAT_GOOD_RST = 1'h0;
    localparam logic        LAST_PWR_RST = 1'h0;
    localparam wmc_led_option_select_t LED_OPTION_SELECT_RST = WMC_LED_SPC;
    localparam logic        SHUT_ORDERLY = 1'h0;
    localparam logic        SHUT_FORCED  = 1'h1;
endpackage

// file: rtl/wmc_if.sv
/*
 * Carrier between the register top and its domain sub-blocks: one host
 * write strobe with byte data, and the lock that gates it.
 * Assumes one clock shared by all users.
 */
`timescale 1ns/1ps
`default_nettype none
interface wmc_wr_if;
    logic       wr_en;
    logic [7:0] wr_data;
    logic       locked;
    modport top (output wr_en, output wr_data, input locked);
    modport lock (input wr_en, input wr_data, output locked);
    modport bat (input wr_en, input wr_data, input locked);
endinterface
`default_nettype wire

// file: rtl/wmc_lock.sv
/*
 * Standby-domain configuration lock, write-one-to-set.
 * Assumes the standby reset is asynchronous active low.
 */
`timescale 1ns/1ps
`default_nettype none
module wmc_lock (
    input  wire logic clk_in,
    input  wire logic nrst_sb_in,
    wmc_wr_if.lock    bus
);
    logic lock_ff;

    // Once set only the standby reset clears it
    always_ff @(posedge clk_in or negedge nrst_sb_in) begin
        if (!nrst_sb_in) begin
            lock_ff <= wmc_pkg::LOCK_RST;
        end else if (bus.wr_en && bus.wr_data[wmc_pkg::BIT_LOCK]) begin
            lock_ff <= 1'b1;
        end
    end

    assign bus.locked = lock_ff;
endmodule
`default_nettype wire

// file: rtl/wmc_bat.sv
/*
 * Battery-domain fields: battery good, last power state, LED option.
 * Assumes supply and sleep indications are synchronous to clk_in.
 */
`timescale 1ns/1ps
`default_nettype none
module wmc_bat (
    input  wire logic                 clk_in,
    input  wire logic                 nrst_bat_in,
    input  wire logic                 battery_low_in,
    input  wire logic                 main_supply_fail_in,
    input  wire logic                 standby_supply_fail_in,
    input  wire logic                 sleep_s3_indication_in,
    wmc_wr_if.bat                     bus,
    output logic                      battery_good_out,
    output logic                      last_power_state_out,
    output wmc_pkg::wmc_led_option_select_t     led_option_select_out
);
    logic                  bat_good_ff;
    logic                  last_pwr_ff;
    logic                  main_fail_ff;
    wmc_pkg::wmc_led_option_select_t led_option_select_ff;

    // ****************************************
    // Battery good
    // ****************************************
    always_ff @(posedge clk_in or negedge nrst_bat_in) begin
        if (!nrst_bat_in) begin
            bat_good_ff <= wmc_pkg::BAT_GOOD_RST;
        end else if (battery_low_in) begin
            bat_good_ff <= 1'b0;
        end else if (main_supply_fail_in || standby_supply_fail_in) begin
            bat_good_ff <= 1'b1;
        end
    end
    // Low battery forces 0 at once, not one clock later
    assign battery_good_out = bat_good_ff && !battery_low_in;

    // ****************************************
    // Last power state
    // ****************************************
    always_ff @(posedge clk_in or negedge nrst_bat_in) begin
        if (!nrst_bat_in) begin
            main_fail_ff <= 1'b0;
        end else begin
            main_fail_ff <= main_supply_fail_in;
        end
    end

    // Capture only on the failing edge; host writes never reach it
    always_ff @(posedge clk_in or negedge nrst_bat_in) begin
        if (!nrst_bat_in) begin
            last_pwr_ff <= wmc_pkg::LAST_PWR_RST;
        end else if (battery_low_in) begin
            last_pwr_ff <= wmc_pkg::LAST_PWR_RST;
        end else if (main_supply_fail_in && !main_fail_ff) begin
            last_pwr_ff <= sleep_s3_indication_in;
        end
    end
    assign last_power_state_out = last_pwr_ff;

    // ****************************************
    // LED option select
    // ****************************************
    always_ff @(posedge clk_in or negedge nrst_bat_in) begin
        if (!nrst_bat_in) begin
            led_option_select_ff <= wmc_pkg::LED_OPTION_SELECT_RST;
        end else if (bus.wr_en && !bus.locked) begin
            led_option_select_ff <= wmc_pkg::wmc_led_option_select_t'(
                bus.wr_data[wmc_pkg::BIT_LED_HI:wmc_pkg::BIT_LED_LO]);
        end
    end
    assign led_option_select_out = led_option_select_ff;
endmodule
`default_nettype wire

// file: rtl/wmc_top.sv
/*
 * Miscellaneous control and status register of the wake-up control unit.
 * Holds the config lock, battery status, last power state and LED option,
 * and hands out write-lock and LED-scheme selects to neighbour registers.
 * Assumes a synchronous byte register port already offset from the base.
 */
//
// Behaviour
// - Misc control register sits at offset 01h of the window.
// - Lock bit 7 is write-one-to-set, writing 0 does nothing, resets 0.
// - Lock blocks writes to this and the listed LED, keyboard, PS/2 registers.
// - Software cannot clear lock; only hardware reset returns it to 0.
// - Battery-good bit 5 clears at once whenever battery low.
// - With battery fine, supply-fail indication sets battery-good.
// - Battery-good reads 0 for low or absent battery, 1 when good; the code reads 1 only once a supply-fail indication has set it.
// - Last power state bit 2 captures S3 sleep level at main failure.
// - Host writes never change the last power state.
// - Battery-domain power-up reset clears last power state.
// - Last power state 0 means orderly shutdown, 1 forced.
// - LED option bits 1-0: 00 advanced, 01 standard, 11 reserved.
// - LED option 10 selects special control and is the reset value.
// - Lock resets with standby domain, other fields with battery domain.
// - Offsets are relative to base held at config indexes 60h-61h.
`timescale 1ns/1ps
`default_nettype none
module wmc_top (
    input  wire logic        clk_in,
    input  wire logic        nrst_in,
    input  wire logic        nrst_bat_in,
    input  wire logic [3:0]  reg_addr_in,
    input  wire logic        reg_wr_in,
    input  wire logic [7:0]  reg_wdata_in,
    output logic      [7:0]  reg_rdata_out,
    input  wire logic        battery_low_in,
    input  wire logic        main_supply_fail_in,
    input  wire logic        standby_supply_fail_in,
    input  wire logic        sleep_s3_indication_in,
    output logic             config_lock_out,
    output logic             battery_good_out,
    output logic             last_power_state_out,
    output logic      [1:0]  led_option_select_out,
    output logic             standard_led_sel_out,
    output logic             advanced_led_sel_out,
    output logic             special_led_sel_out,
    output logic             led_blink_sel_out,
    output logic             std_led_bits_wr_en_out,
    output logic             locked_reg_wr_en_out
);
    wmc_wr_if              wr_bus ();
    wmc_pkg::wmc_led_option_select_t led_option_select;
    logic                  misc_hit;
    logic                  locked_target;
    logic [7:0]            nxt_rdata;
    logic [7:0]            rdata_ff;

    // ****************************************
    // Address decode
    // ****************************************
    // Window offsets are already base-relative: base decode lives upstream
    assign misc_hit = (reg_addr_in == wmc_pkg::OFF_MISC_CTL);
    assign wr_bus.wr_en   = reg_wr_in && misc_hit;
    assign wr_bus.wr_data = reg_wdata_in;

    wmc_lock u_lock (
        .clk_in     (clk_in),
        .nrst_sb_in (nrst_in),
        .bus        (wr_bus)
    );

    wmc_bat u_bat (
        .clk_in                 (clk_in),
        .nrst_bat_in            (nrst_bat_in),
        .battery_low_in         (battery_low_in),
        .main_supply_fail_in    (main_supply_fail_in),
        .standby_supply_fail_in (standby_supply_fail_in),
        .sleep_s3_indication_in (sleep_s3_indication_in),
        .bus                    (wr_bus),
        .battery_good_out       (battery_good_out),
        .last_power_state_out   (last_power_state_out),
        .led_option_select_out  (led_option_select)
    );

    assign config_lock_out       = wr_bus.locked;
    assign led_option_select_out = led_option_select;

    // ****************************************
    // LED scheme selects
    // ****************************************
    assign standard_led_sel_out = (led_option_select == wmc_pkg::WMC_LED_STD);
    assign advanced_led_sel_out = (led_option_select == wmc_pkg::WMC_LED_ADV);
    assign led_blink_sel_out    = (led_option_select == wmc_pkg::WMC_LED_ADV);
    assign special_led_sel_out  = (led_option_select == wmc_pkg::WMC_LED_SPC);

    // ****************************************
    // Write gating for neighbour registers
    // ****************************************
    always_comb begin
        locked_target = 1'b0;
        unique case (reg_addr_in)
            wmc_pkg::OFF_ADV_SPC_LED,
            wmc_pkg::OFF_BLINK_LED,
            wmc_pkg::OFF_KBD_WAKE,
            wmc_pkg::OFF_PS2_CTL: begin
                locked_target = 1'b1;
            end
            default: begin
                locked_target = (reg_addr_in >= wmc_pkg::OFF_KEY_FIRST)
                             && (reg_addr_in <= wmc_pkg::OFF_KEY_LAST);
            end
        endcase
    end
    assign locked_reg_wr_en_out =
        reg_wr_in && locked_target && !wr_bus.locked;
    // Blink and colour bits of the standard register follow the lock, and are writable only while the standard option is selected
    assign std_led_bits_wr_en_out = reg_wr_in && !wr_bus.locked
        && (reg_addr_in == wmc_pkg::OFF_STD_LED)
        && (led_option_select == wmc_pkg::WMC_LED_STD);

    // ****************************************
    // Read data
    // ****************************************
    always_comb begin
        nxt_rdata = 8'h00;
        if (misc_hit) begin
            nxt_rdata[wmc_pkg::BIT_LOCK]     = wr_bus.locked;
            nxt_rdata[wmc_pkg::BIT_BAT_GOOD] = battery_good_out;
            nxt_rdata[wmc_pkg::BIT_LAST_PWR] = last_power_state_out;
            nxt_rdata[wmc_pkg::BIT_LED_HI:wmc_pkg::BIT_LED_LO] = led_option_select;
        end
    end

    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            rdata_ff <= 8'h00;
        end else begin
            rdata_ff <= nxt_rdata;
        end
    end
    assign reg_rdata_out = rdata_ff;
endmodule
`default_nettype wire

// file: testbench/wmc_checker.sv
/* Concurrent checks on the ports of the misc control register top.
   Assumes one clock and that either active-low reset suspends the checks. */
`timescale 1ns/1ps
`default_nettype none
module wmc_checker (
    input wire logic       clk_in,
    input wire logic       nrst_in,
    input wire logic       nrst_bat_in,
    input wire logic [3:0] reg_addr_in,
    input wire logic       reg_wr_in,
    input wire logic [7:0] reg_wdata_in,
    input wire logic [7:0] reg_rdata_out,
    input wire logic       battery_low_in,
    input wire logic       main_supply_fail_in,
    input wire logic       standby_supply_fail_in,
    input wire logic       sleep_s3_indication_in,
    input wire logic       config_lock_out,
    input wire logic       battery_good_out,
    input wire logic       last_power_state_out,
    input wire logic [1:0] led_option_select_out,
    input wire logic       standard_led_sel_out,
    input wire logic       advanced_led_sel_out,
    input wire logic       special_led_sel_out,
    input wire logic       led_blink_sel_out,
    input wire logic       std_led_bits_wr_en_out,
    input wire logic       locked_reg_wr_en_out
);
    wire logic misc_wr  = reg_wr_in && reg_addr_in == 4'h1;
    wire logic any_fail = main_supply_fail_in || standby_supply_fail_in;
    wire logic ok_bat   = !battery_low_in;
    default clocking cb @(posedge clk_in); endclocking
    // Either reset alone moves fields, so both suspend the checks
    default disable iff (!nrst_in || !nrst_bat_in);
    a_lock_sticky: assert property (config_lock_out |=> config_lock_out)
        else $error("lock cleared");
    a_led_frozen: assert property (config_lock_out |=> $stable(led_option_select_out))
        else $error("option moved while locked");
    a_led_write: assert property (misc_wr && !config_lock_out
        |=> led_option_select_out == $past(reg_wdata_in[1:0])) else $error("option lost");
    a_bat_low: assert property (battery_low_in |-> !battery_good_out)
        else $error("good while low");
    a_bat_set: assert property ((ok_bat && any_fail) ##1 ok_bat
        |-> battery_good_out) else $error("good not set");
    a_last_cap: assert property (($rose(main_supply_fail_in) && ok_bat) ##1 ok_bat
        |-> last_power_state_out == $past(sleep_s3_indication_in)) else $error("no capture");
    a_last_hold: assert property ((!$rose(main_supply_fail_in) && ok_bat) ##1 ok_bat
        |-> $stable(last_power_state_out)) else $error("state changed");
    a_wr_gate: assert property (locked_reg_wr_en_out || std_led_bits_wr_en_out
        |-> reg_wr_in && !config_lock_out) else $error("enable while locked");
    c_locked_wr: cover property (config_lock_out && reg_wr_in);
    c_good: cover property ($rose(battery_good_out));
    c_forced: cover property ($rose(last_power_state_out));
endmodule
bind wmc_top wmc_checker u_chk (.*);
`default_nettype wire

// file: testbench/tb.sv
/* Self-checking bench for the misc control register top.
   Assumes the package, interface, design and checker are compiled first. */
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic       clk_in = 1'b0;
    logic       nrst_in = 1'b0;
    logic       nrst_bat_in = 1'b0;
    logic [3:0] reg_addr_in = 4'h0;
    logic       reg_wr_in = 1'b0;
    logic [7:0] reg_wdata_in = 8'h00;
    logic       battery_low_in = 1'b0;
    logic       main_supply_fail_in = 1'b0;
    logic       standby_supply_fail_in = 1'b0;
    logic       sleep_s3_indication_in = 1'b0;
    logic [7:0] reg_rdata_out;
    logic [1:0] led_option_select_out;
    logic       config_lock_out, battery_good_out, last_power_state_out;
    logic       standard_led_sel_out, advanced_led_sel_out, special_led_sel_out;
    logic       led_blink_sel_out, std_led_bits_wr_en_out, locked_reg_wr_en_out;
    logic       e_lock = 1'b0;
    logic       e_good = 1'b0;
    logic       e_last = 1'b0;
    logic [1:0] e_opt = 2'h2;
    logic [7:0] d;
    int         failures = 0;
    int         total_checks = 0;
    int         i;
    wmc_top uut (.*);
    always #25 clk_in = ~clk_in;
    function automatic logic [7:0] exp_misc();
        return {e_lock, 1'b0, e_good, 2'b00, e_last, e_opt};
    endfunction
    function automatic logic [7:0] exp_sel();
        return {4'h0, e_opt == 2'h1, e_opt == 2'h0, e_opt == 2'h2, e_opt == 2'h0};
    endfunction
    task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string msg);
        total_checks++;
        if (got !== exp) begin
            failures++;
            $display("[FAIL] %0t %s got %h exp %h", $time, msg, got, exp);
        end
    endtask
    task automatic st();
        logic [7:0] f;
        logic [7:0] s;
        f = {config_lock_out, 1'b0, battery_good_out, 2'b00, last_power_state_out,
             led_option_select_out};
        s = {4'h0, standard_led_sel_out, advanced_led_sel_out, special_led_sel_out,
             led_blink_sel_out};
        chk(f, exp_misc(), "fields");
        chk(s, exp_sel(), "scheme");
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] v);
        logic       lk;
        logic       sd;
        logic [7:0] g;
        @(negedge clk_in);
        lk = !e_lock && ((a >= 4'h2 && a <= 4'h5) || a >= 4'h8);
        sd = !e_lock && a == 4'h0 && e_opt == 2'h1;
        reg_addr_in = a;
        reg_wdata_in = v;
        reg_wr_in = 1'b1;
        #1;
        g = {6'h00, std_led_bits_wr_en_out, locked_reg_wr_en_out};
        chk(g, {6'h00, sd, lk}, "wr en");
        @(negedge clk_in);
        reg_wr_in = 1'b0;
        if (a == 4'h1 && !e_lock) begin
            e_lock = v[7];
            e_opt = v[1:0];
        end
    endtask
    task automatic rd(input logic [3:0] a);
        @(negedge clk_in);
        reg_addr_in = a;
        @(negedge clk_in);
        chk(reg_rdata_out, a == 4'h1 ? exp_misc() : 8'h00, "read");
    endtask
    task automatic complete_run();
        $display("checks %0d failures %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    initial begin
        void'($urandom(32'h1f96));
        repeat (5) @(negedge clk_in);
        nrst_in = 1'b1;
        nrst_bat_in = 1'b1;
        st();
        // First writes sweep every option code, then reserved bits all set
        for (i = 0; i < 20; i++) begin
            d = i < 4 ? 8'(i) : (i == 4 ? 8'h7f : 8'($urandom) & 8'h7f);
            wr(i < 5 ? 4'h1 : 4'($urandom), d);
            rd(4'($urandom));
            rd(4'h1);
        end
        for (i = 0; i < 3; i++) begin
            sleep_s3_indication_in = (i != 1);
            main_supply_fail_in = 1'b1;
            e_good = 1'b1;
            e_last = (i != 1);
            repeat (2) @(negedge clk_in);
            st();
            main_supply_fail_in = 1'b0;
            wr(4'h1, 8'($urandom) & 8'h27);
            st();
            // Status bits must also show through the read path
            rd(4'h1);
        end
        battery_low_in = 1'b1;
        standby_supply_fail_in = 1'b1;
        e_good = 1'b0;
        e_last = 1'b0;
        #1;
        // Software must not trust the last power state from here on
        chk({7'h00, battery_good_out}, 8'h00, "low");
        repeat (2) @(negedge clk_in);
        st();
        battery_low_in = 1'b0;
        e_good = 1'b1;
        repeat (2) @(negedge clk_in);
        st();
        standby_supply_fail_in = 1'b0;
        wr(4'h1, 8'h01);
        wr(4'h0, 8'h03);
        wr(4'h1, 8'h81);
        st();
        rd(4'h1);
        for (i = 0; i < 16; i++) begin
            wr(4'(i), 8'($urandom));
        end
        wr(4'h1, 8'h02);
        st();
        nrst_bat_in = 1'b0;
        @(negedge clk_in);
        nrst_bat_in = 1'b1;
        e_good = 1'b0;
        e_opt = 2'h2;
        st();
        nrst_in = 1'b0;
        @(negedge clk_in);
        chk(reg_rdata_out, 8'h00, "rst read");
        nrst_in = 1'b1;
        e_lock = 1'b0;
        wr(4'h1, 8'h01);
        st();
        rd(4'h1);
        complete_run();
    end
endmodule
`default_nettype wire
